// [hbp_assertions.sv]
// assertion checker on the host bus pin control ports
`timescale 1ns/1ps
`default_nettype none
module hbp_checker
  import hbp_pkg::*;
(
  input wire logic     hclk,
  input wire logic     hresetn,
  input wire logic     address_qualifier_n,
  input wire logic     address_latch_strobe_n,
  input wire logic     write_strobe_n,
  input wire logic     read_strobe_n,
  input wire logic     sync_write_not_read,
  input wire logic     bus_clk_in,
  input wire logic     eeprom_serial_in,
  input wire logic     eeprom_enable_strap,
  input wire logic     sync_mode_strap_n,
  input wire logic     chip_power_down_n,
  input wire logic     local_select_n,
  input wire logic     chip_power_down,
  input wire logic     eeprom_rom_data,
  input wire logic     bus_width_16,
  input wire logic     read_active,
  input wire hbp_acc_t host_access
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // stable qualifier only: with the strobe low the select follows the qualifier pin in the same cycle
  unqual_sel_a: assert property (address_qualifier_n && !address_latch_strobe_n
    && $stable(address_qualifier_n) |-> local_select_n) else $error("select without qualifier");
  access_ours_a: assert property (host_access.valid
    |-> !$past(local_select_n)) else $error("access while not selected");
  valid_pulse_a: assert property (host_access.valid
    |=> !host_access.valid) else $error("valid longer than one cycle");
  sync_dir_a: assert property (!sync_mode_strap_n && $rose(bus_clk_in) && $past(hresetn)
    && !local_select_n && !chip_power_down |=> host_access.valid && read_active ==
    !host_access.write && host_access.write == $past(sync_write_not_read))
    else $error("sync access direction wrong");
  async_wr_a: assert property (sync_mode_strap_n && host_access.valid && host_access.write
    |-> !$past(write_strobe_n)) else $error("write without strobe");
  async_rd_a: assert property (sync_mode_strap_n && read_active
    |-> !$past(read_strobe_n) || !$past(read_strobe_n, 2)) else $error("read without strobe");
  power_down_a: assert property ($past(hresetn)
    |-> chip_power_down == !$past(chip_power_down_n)) else $error("power down wrong");
  rom_data_a: assert property ($past(hresetn, 2) |-> eeprom_rom_data ==
    ($past(eeprom_serial_in) && eeprom_enable_strap)) else $error("rom data wrong");
  strap_width_a: assert property (!eeprom_enable_strap && $past(hresetn)
    |-> bus_width_16 == eeprom_serial_in) else $error("bus width wrong");
endmodule
bind hbp_top hbp_checker chk_i (.*);
`default_nettype wire

// [hbp_host_model.sv]
// host processor model driving the local bus pins
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model (
  input  wire logic  hclk,
  output logic [15:1] host_addr,
  output logic        address_qualifier_n,
  output logic        address_latch_strobe_n,
  output logic        write_strobe_n,
  output logic        read_strobe_n,
  output logic        sync_write_not_read,
  output logic        bus_clk_in
);
  initial begin
    host_addr = 15'h0000;
    address_qualifier_n = 1'b1;
    address_latch_strobe_n = 1'b0;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    sync_write_not_read = 1'b0;
    bus_clk_in = 1'b0;
  end
  task put(input logic [15:1] a, input logic l);
    @(posedge hclk);
    host_addr <= a;
    address_qualifier_n <= 1'b0;
    address_latch_strobe_n <= 1'b0;
    @(posedge hclk);
    if (l) begin
      address_latch_strobe_n <= 1'b1;
      @(posedge hclk);
      // pins wander after the latch edge, only the latch may count
      host_addr <= ~a;
      address_qualifier_n <= 1'b1;
    end
  endtask
  task access(input logic sync, input logic w);
    @(posedge hclk);
    sync_write_not_read <= w;
    if (!sync && w) write_strobe_n <= 1'b0;
    if (!sync && !w) read_strobe_n <= 1'b0;
    @(posedge hclk);
    bus_clk_in <= sync;
    repeat (3) @(posedge hclk);
    bus_clk_in <= 1'b0;
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (2) @(posedge hclk);
    // released: qualifier pulled up, address lines left inverted
    address_latch_strobe_n <= 1'b0;
    address_qualifier_n <= 1'b1;
    host_addr <= ~host_addr;
  endtask
endmodule
`default_nettype wire

// [hbp_map.svh]
// register offsets, field positions and reset values of the host bus pin control block
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH
`define HBP_OFS_BASE       8'h00
`define HBP_OFS_CTRL       8'h04
`define HBP_OFS_STATUS     8'h08
`define HBP_OFS_LAST       8'h0c
`define HBP_BASE_RST       12'h030
`define HBP_CTRL_EN_BIT    0
`define HBP_CTRL_W16_BIT   1
`define HBP_CTRL_RST       2'h3
`define HBP_ST_W16_BIT     0
`define HBP_ST_EEN_BIT     1
`define HBP_ST_SYNC_BIT    2
`define HBP_ST_PDN_BIT     3
`define HBP_ST_SEL_BIT     4
`define HBP_ST_RD_BIT      5
`define HBP_ST_DONE_BIT    6
`define HBP_LAST_WR_BIT    16
`define HBP_LAST_CNT_LSB   24
`define HBP_ADDR_LSB       2
`define HBP_ADDR_MSB       7
`endif

// [hbp_pkg.sv]
// types shared by the host bus pin control block
`default_nettype none
package hbp_pkg;
  typedef enum logic {HBP_W8, HBP_W16} hbp_width_t;
  typedef enum logic [1:0] {HBP_IDLE, HBP_WR_HOLD, HBP_RD_HOLD} hbp_state_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:1] addr;
  } hbp_acc_t;
  typedef struct packed {
    logic       done;
    logic       eeprom_en;
    logic       sync_mode;
    hbp_width_t width;
  } hbp_strap_t;
endpackage
`default_nettype wire

// [hbp_top.sv]
// host bus pin control: strap capture, address latch and decode, access direction, ahb registers
`timescale 1ns/1ps
`default_nettype none
`include "hbp_map.svh"
module hbp_top
  import hbp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:1] host_addr,
  input  wire logic        address_qualifier_n,
  input  wire logic        address_latch_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        sync_write_not_read,
  input  wire logic        bus_clk_in,
  input  wire logic        eeprom_serial_in,
  input  wire logic        eeprom_enable_strap,
  input  wire logic        sync_mode_strap_n,
  input  wire logic        chip_power_down_n,
  output logic             local_select_n,
  output logic             chip_power_down,
  output logic             eeprom_rom_data,
  output logic             bus_width_16,
  output logic             read_active,
  output hbp_acc_t         host_access
);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture, taken by a clocked process after reset release
  hbp_strap_t strap_r, strap_nxt;
  logic       pdn_r, pdn_nxt;
  logic       eerom_r, eerom_nxt;
  logic [1:0] ctrl_r;

  always_comb begin
    strap_nxt = strap_r;
    if (!strap_r.done) begin
      strap_nxt.done      = 1'b1;
      strap_nxt.eeprom_en = eeprom_enable_strap;
      strap_nxt.sync_mode = ~sync_mode_strap_n;
      // eeprom fitted: width comes from the loaded control setting instead
      strap_nxt.width     = eeprom_serial_in ? HBP_W16 : HBP_W8;
    end
    pdn_nxt   = ~chip_power_down_n;
    eerom_nxt = strap_r.eeprom_en & eeprom_serial_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_r <= '{done: 1'b0, eeprom_en: 1'b0, sync_mode: 1'b0, width: HBP_W8};
      pdn_r   <= 1'b0;
      eerom_r <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
      pdn_r   <= pdn_nxt;
      eerom_r <= eerom_nxt;
    end
  end

  logic width16;
  assign width16 = strap_r.eeprom_en ? ctrl_r[`HBP_CTRL_W16_BIT]
                                     : (strap_r.width == HBP_W16);

  assign chip_power_down = pdn_r;
  assign eeprom_rom_data = eerom_r;
  assign bus_width_16    = width16;

  ////////////////////////////////////////////////////////////////////////////
  // address latch and decode
  logic [15:1] lat_addr_r, lat_addr_nxt;
  logic        lat_q_r, lat_q_nxt;
  logic [15:1] eff_addr;
  logic        eff_q_n;
  logic [11:0] base_r;

  always_comb begin
    lat_addr_nxt = lat_addr_r;
    lat_q_nxt    = lat_q_r;
    // tracking while low leaves the value seen at the rising edge held
    if (!address_latch_strobe_n) begin
      lat_addr_nxt = host_addr;
      lat_q_nxt    = address_qualifier_n;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_addr_r <= '0;
      lat_q_r    <= 1'b1;
    end else begin
      lat_addr_r <= lat_addr_nxt;
      lat_q_r    <= lat_q_nxt;
    end
  end

  assign eff_addr = address_latch_strobe_n ? lat_addr_r : host_addr;
  assign eff_q_n  = address_latch_strobe_n ? lat_q_r : address_qualifier_n;

  logic selected;
  assign selected = ~eff_q_n & (eff_addr[15:4] == base_r) & ~pdn_r;
  assign local_select_n = ~selected;

  ////////////////////////////////////////////////////////////////////////////
  // access generation
  hbp_state_t st_r, st_nxt;
  hbp_acc_t   acc_r, acc_nxt;
  logic       bclk_d_r, bclk_d_nxt;
  logic       rd_r, rd_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       go;

  assign go = selected & ctrl_r[`HBP_CTRL_EN_BIT] & strap_r.done;

  always_comb begin
    st_nxt       = st_r;
    acc_nxt      = acc_r;
    acc_nxt.valid = 1'b0;
    bclk_d_nxt   = bus_clk_in;
    rd_nxt       = 1'b0;
    cnt_nxt      = cnt_r;
    if (strap_r.sync_mode) begin
      st_nxt = HBP_IDLE;
      // bus clock only matters here; in async mode it is ignored
      if (go && bus_clk_in && !bclk_d_r) begin
        acc_nxt.valid = 1'b1;
        acc_nxt.write = sync_write_not_read;
        acc_nxt.addr  = eff_addr;
        rd_nxt        = ~sync_write_not_read;
      end
    end else begin
      case (st_r)
        HBP_IDLE: begin
          if (go && !write_strobe_n) begin
            st_nxt        = HBP_WR_HOLD;
            acc_nxt.valid = 1'b1;
            acc_nxt.write = 1'b1;
            acc_nxt.addr  = eff_addr;
          end else if (go && !read_strobe_n) begin
            st_nxt        = HBP_RD_HOLD;
            acc_nxt.valid = 1'b1;
            acc_nxt.write = 1'b0;
            acc_nxt.addr  = eff_addr;
            rd_nxt        = 1'b1;
          end
        end
        HBP_WR_HOLD: begin
          // one access per strobe, however long the strobe stays low
          if (write_strobe_n) st_nxt = HBP_IDLE;
        end
        HBP_RD_HOLD: begin
          rd_nxt = ~read_strobe_n;
          if (read_strobe_n) st_nxt = HBP_IDLE;
        end
        default: st_nxt = HBP_IDLE;
      endcase
    end
    if (acc_nxt.valid) cnt_nxt = cnt_r + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= HBP_IDLE;
      acc_r    <= '0;
      bclk_d_r <= 1'b0;
      rd_r     <= 1'b0;
      cnt_r    <= '0;
    end else begin
      st_r     <= st_nxt;
      acc_r    <= acc_nxt;
      bclk_d_r <= bclk_d_nxt;
      rd_r     <= rd_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign host_access = acc_r;
  assign read_active = rd_r;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states
  logic        ap_wr_r, ap_wr_nxt;
  logic [7:0]  ap_ofs_r, ap_ofs_nxt;
  logic [11:0] base_nxt;
  logic [1:0]  ctrl_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] status_w;
  logic [31:0] last_w;
  logic [7:0]  ofs;
  logic        take;

  assign take = hsel & hready & htrans[1];
  assign ofs  = {haddr[`HBP_ADDR_MSB:`HBP_ADDR_LSB], 2'b00};

  always_comb begin
    status_w = '0;
    status_w[`HBP_ST_W16_BIT]  = width16;
    status_w[`HBP_ST_EEN_BIT]  = strap_r.eeprom_en;
    status_w[`HBP_ST_SYNC_BIT] = strap_r.sync_mode;
    status_w[`HBP_ST_PDN_BIT]  = pdn_r;
    status_w[`HBP_ST_SEL_BIT]  = selected;
    status_w[`HBP_ST_RD_BIT]   = rd_r;
    status_w[`HBP_ST_DONE_BIT] = strap_r.done;
    last_w = {cnt_r, 7'h00, acc_r.write, acc_r.addr, 1'b0};
  end

  always_comb begin
    ap_wr_nxt  = 1'b0;
    ap_ofs_nxt = ap_ofs_r;
    base_nxt   = base_r;
    ctrl_nxt   = ctrl_r;
    rdata_nxt  = rdata_r;
    if (ap_wr_r) begin
      case (ap_ofs_r)
        `HBP_OFS_BASE: base_nxt = hwdata[15:4];
        `HBP_OFS_CTRL: ctrl_nxt = hwdata[1:0];
        default:       base_nxt = base_r;
      endcase
    end
    if (take) begin
      ap_wr_nxt  = hwrite;
      ap_ofs_nxt = ofs;
      // read data fetched in the address phase; a write just before is seen
      case (ofs)
        `HBP_OFS_BASE:   rdata_nxt = {16'h0000, base_nxt, 4'h0};
        `HBP_OFS_CTRL:   rdata_nxt = {30'h0, ctrl_nxt};
        `HBP_OFS_STATUS: rdata_nxt = status_w;
        `HBP_OFS_LAST:   rdata_nxt = last_w;
        default:         rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r  <= 1'b0;
      ap_ofs_r <= '0;
      base_r   <= `HBP_BASE_RST;
      ctrl_r   <= `HBP_CTRL_RST;
      rdata_r  <= '0;
    end else begin
      ap_wr_r  <= ap_wr_nxt;
      ap_ofs_r <= ap_ofs_nxt;
      base_r   <= base_nxt;
      ctrl_r   <= ctrl_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

endmodule
`default_nettype wire

// [hbp_top_bench.sv]
// self-checking bench of the host bus pin control block
`timescale 1ns/1ps
`default_nettype none
module hbp_top_bench;
  import hbp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, w, hreadyout, eeprom_serial_in;
  logic        eeprom_enable_strap, sync_mode_strap_n, chip_power_down_n;
  logic        local_select_n, chip_power_down, eeprom_rom_data, bus_width_16;
  logic        read_active, address_qualifier_n, address_latch_strobe_n;
  logic        write_strobe_n, read_strobe_n, sync_write_not_read, bus_clk_in;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, b;
  logic [15:1] x, host_addr;
  hbp_acc_t    host_access;
  int          failures = 0;
  int          cmp_count = 0;
  hbp_top uut (.hsize(3'h2), .hready(hreadyout), .hresp(), .*);
  hbp_host_model host (.*);
  initial begin
    hclk = 1'b0;
    // hclk stands in for the device reference clock
    forever #25 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////////
  task conclude;
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        failures++;
        conclude;
      end
      @(posedge hclk);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    eeprom_serial_in = 1'b0;
    eeprom_enable_strap = 1'b0;
    sync_mode_strap_n = 1'b0;
    chip_power_down_n = 1'b1;
    r = $urandom(78);
    for (int m = 0; m < 4; m++) begin
      hresetn <= 1'b0;
      sync_mode_strap_n <= m[1];
      eeprom_enable_strap <= (m == 3);
      eeprom_serial_in <= m[0];
      repeat (2) @(posedge hclk);
      // hard reset hold scaled down to two edges to keep the run short
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      ahb(0, 8'h08, 0);
      chk("status", r[2:0], {!m[1], m == 3, m[0]});
      chk("width", bus_width_16, m[0]);
      if (m == 3) begin
        ahb(1, 8'h04, 32'h1);
        @(negedge hclk);
        chk("strap ignored", bus_width_16, 0);
      end
      ahb(0, 8'h1c, 0);
      chk("unmapped", r, 0);
      b = $urandom;
      ahb(1, 8'h00, b);
      ahb(0, 8'h00, 0);
      chk("base", r, b & 32'hfff0);
      x = {b[15:4], 3'($urandom)};
      host.put(x ^ 15'h0800, 0);
      @(negedge hclk);
      chk("miss", local_select_n, 1);
      for (int k = 0; k < 2; k++) begin
        w = k[0] ^ m[0];
        host.put(x, k[0]);
        @(negedge hclk);
        chk("hit", local_select_n, 0);
        fork
          host.access(!m[1], w);
          begin
            repeat (3) @(negedge hclk);
            chk("reading", read_active, !w);
          end
        join
        chk("access", host_access[15:0], {w, x});
      end
      ahb(0, 8'h0c, 0);
      chk("last", r, {8'h02, 7'h00, w, x, 1'b0});
      @(posedge hclk);
      chip_power_down_n <= 1'b0;
      host.put(x, 0);
      @(negedge hclk);
      chk("pdown", {chip_power_down, local_select_n}, 2'b11);
      @(posedge hclk);
      chip_power_down_n <= 1'b1;
      if (m == 3) repeat (8) begin
        @(posedge hclk);
        eeprom_serial_in <= 1'($urandom);
        repeat (2) @(negedge hclk);
        chk("rom", eeprom_rom_data, eeprom_serial_in);
      end
    end
    conclude;
  end
endmodule
`default_nettype wire
